// File: gle_expander.sv
// The address map and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
// How it works
// [R01] All eight general ports come out of reset as inputs.
// [R02] Input register shows live synchronised level of every port pin.
// [R03] Each read of the input register stores those levels as the snapshot.
// [R04] Input-mode ports differing from snapshot pull the ninth pin low in interrupt mode.
// [R05] Change interrupt drops when inputs match snapshot again or input register read.
// [R06] Ninth pin is change interrupt or a ninth output with the same controls.
// [R07] With blinking off, phase-zero register alone sets the outputs.
// [R08] With blinking on, flip flag picks phase-zero or phase-one register.
// [R09] PWM ticks come from a divider making a nominal 32 kHz rate.
// [R10] PWM is chosen per output; others are registered static levels.
// [R11] With no PWM output, all outputs static and the oscillator halted.
// [R12] A 4-bit master intensity with 16 levels applies to all PWM outputs.
// [R13] Master sets the window in fifteenths of the PWM period.
// [R14] Per-output 4-bit value gives sixteenths of the master window.
// [R15] Global mode uses one common 4-bit value for all outputs, 16 levels.
// [R16] Idle serial bus and no PWM output means automatic standby.
// [R17] Command byte alone only stores the register selection.
// [R18] Master intensity zero keeps PWM outputs fully off.
module gle_expander
    import gle_pkg::*;
#(
    parameter int OSC_TICKS = OSC_TICK_CYCLES
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic ce,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic [7:0] general_port_pins_in,
    output logic [7:0] general_port_pins_out,
    output logic [7:0] general_port_pins_oe,
    output logic irq_or_ninth_output_out,
    output logic irq_or_ninth_output_oe,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic standby,
    output logic irq
);

    gle_state_t s_r;
    gle_state_t s_nxt;

    function automatic logic [7:0] duty(input logic [3:0] m, input logic [3:0] i);
        // Window m*16 of 240 ticks, then i/16 of that
        return {4'h0, m} * {4'h0, i}; // [R13] [R14]
    endfunction : duty

    function automatic logic [31:0] rd_word(input gle_state_t s, input logic [7:0] ofs);
        logic [31:0] v;
        v = 32'h0;
        unique case ({ofs[7:2], 2'b00})
            OFS_INPUT: v[7:0] = s.port_s2; // [R02]
            OFS_PHASE0: v[8:0] = s.ph0;
            OFS_CONFIG: v[3:0] = s.cfg;
            OFS_DIR: v[7:0] = s.dir;
            OFS_PHASE1: v[8:0] = s.ph1;
            OFS_PWM_EN: v[8:0] = s.pwm_en;
            OFS_MASTER: v[3:0] = s.master;
            OFS_INTENS: v = s.intens[7:0];
            OFS_INTENS8: v[7:0] = {s.glob, s.intens[8]};
            OFS_CMD: v[5:0] = s.cmd;
            OFS_IRQ_STAT: v[2:0] = s.ev_stat;
            OFS_IRQ_EN: v[2:0] = s.ev_en;
            OFS_STATUS: v[3:0] = {s.pend, s.busy, |s.pwm_en, s.standby};
            default: v = 32'h0;
        endcase
        return v;
    endfunction : rd_word

    function automatic gle_state_t wr_word(input gle_state_t s, input logic [7:0] ofs,
                                          input logic [31:0] d);
        gle_state_t t;
        t = s;
        unique case ({ofs[7:2], 2'b00})
            OFS_PHASE0: t.ph0 = d[8:0];
            OFS_CONFIG: t.cfg = d[3:0];
            OFS_DIR: t.dir = d[7:0];
            OFS_PHASE1: t.ph1 = d[8:0];
            OFS_PWM_EN: t.pwm_en = d[8:0];
            OFS_MASTER: t.master = d[3:0];
            OFS_INTENS: t.intens[7:0] = d;
            OFS_INTENS8: {t.glob, t.intens[8]} = d[7:0];
            OFS_CMD: t.cmd = d[5:0]; // [R17]
            OFS_IRQ_CLR: t.ev_stat = s.ev_stat & ~d[2:0];
            OFS_IRQ_EN: t.ev_en = d[2:0];
            default: t = s;
        endcase
        return t;
    endfunction : wr_word

    always_comb begin
        logic [7:0] eff;
        logic [31:0] mask;
        logic [31:0] merged;
        logic [7:0] changed;
        logic any_pwm;
        logic [8:0] lvl;
        logic [8:0] sink;
        logic [3:0] ind;
        logic start_c;
        logic stop_c;
        logic [2:0] ev_set;
        eff = 8'h0;
        mask = 32'h0;
        merged = 32'h0;
        changed = 8'h0;
        any_pwm = 1'b0;
        lvl = 9'h0;
        sink = 9'h0;
        ind = 4'h0;
        start_c = 1'b0;
        stop_c = 1'b0;
        ev_set = 3'h0;
        s_nxt = s_r;
        if (ce) begin
            s_nxt.port_s1 = general_port_pins_in;
            s_nxt.port_s2 = s_r.port_s1;
            s_nxt.scl_s = {s_r.scl_s[1:0], scl_in};
            s_nxt.sda_s = {s_r.sda_s[1:0], sda_in};

            // Bus framing seen only from synchronised, settled samples
            start_c = s_r.scl_s[1] && s_r.scl_s[2] && s_r.sda_s[2] && !s_r.sda_s[1];
            stop_c = s_r.scl_s[1] && s_r.scl_s[2] && !s_r.sda_s[2] && s_r.sda_s[1];
            if (start_c) begin
                s_nxt.busy = 1'b1;
            end else if (stop_c) begin
                s_nxt.busy = 1'b0;
            end

            changed = (s_r.port_s2 ^ s_r.snap) & s_r.dir; // [R04]
            s_nxt.pend = |changed; // [R05]

            // Register access: accept one cycle, answer the next
            eff = (address[7:2] == OFS_DATA[7:2]) ? {s_r.cmd, 2'b00} : address;
            if ((read || write) && s_r.wait_r) begin
                s_nxt.wait_r = 1'b0;
                s_nxt.rdata = read ? rd_word(s_r, eff) : 32'h0;
            end else if (!s_r.wait_r) begin
                s_nxt.wait_r = 1'b1;
                s_nxt.rdata = 32'h0;
                if (write) begin
                    mask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                            {8{byteenable[1]}}, {8{byteenable[0]}}};
                    merged = (rd_word(s_r, eff) & ~mask) | (writedata & mask);
                    s_nxt = wr_word(s_nxt, eff, merged);
                end
                if (read && eff[7:2] == OFS_INPUT[7:2]) begin
                    // Snapshot is exactly the value handed to software
                    s_nxt.snap = s_r.rdata[7:0]; // [R03]
                    s_nxt.pend = 1'b0; // [R05]
                end
            end

            any_pwm = |s_r.pwm_en;
            if (!any_pwm) begin
                s_nxt.osc_div = 16'h0; // [R11]
                s_nxt.pwm_cnt = 8'h0; // [R11]
            end else if (s_r.osc_div == 16'(OSC_TICKS - 1)) begin
                s_nxt.osc_div = 16'h0; // [R09]
                s_nxt.pwm_cnt = (s_r.pwm_cnt == PWM_LAST_TICK) ? 8'h0 : s_r.pwm_cnt + 8'h1;
            end else begin
                s_nxt.osc_div = s_r.osc_div + 16'h1; // [R09]
            end

            if (s_r.cfg.blink_en) begin
                lvl = s_r.cfg.flip ? s_r.ph1 : s_r.ph0; // [R08]
            end else begin
                lvl = s_r.ph0; // [R07]
            end
            for (int k = 0; k < 9; k++) begin
                ind = s_r.cfg.global_int ? s_r.glob : s_r.intens[k]; // [R15] [R12]
                if (s_r.pwm_en[k]) begin
                    // Master zero gives duty zero: fully off
                    sink[k] = !lvl[k] && (s_r.pwm_cnt < duty(s_r.master, ind)); // [R10] [R18]
                end else begin
                    sink[k] = !lvl[k]; // [R10]
                end
            end
            s_nxt.pin_oe[7:0] = sink[7:0] & ~s_r.dir; // [R01]
            s_nxt.pin_oe[8] = s_r.cfg.irq_mode ? s_nxt.pend : sink[8]; // [R06] [R04]

            s_nxt.standby = !s_r.busy && !any_pwm; // [R16]

            // Set beats a clear written in the same cycle
            ev_set[EV_CHANGE] = s_nxt.pend && !s_r.pend;
            ev_set[EV_BUS_START] = start_c;
            ev_set[EV_STANDBY] = s_nxt.standby && !s_r.standby;
            s_nxt.ev_stat = s_nxt.ev_stat | ev_set;
            s_nxt.irq = |(s_nxt.ev_stat & s_nxt.ev_en);
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            s_r <= '0;
            s_r.dir <= DIR_RST; // [R01]
            s_r.ph0 <= PHASE_RST;
            s_r.ph1 <= PHASE_RST;
            s_r.cfg <= CFG_RST;
            s_r.scl_s <= 3'h7;
            s_r.sda_s <= 3'h7;
            s_r.wait_r <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Open drain: the driven level is always low
    assign general_port_pins_out = 8'h00;
    assign irq_or_ninth_output_out = 1'b0;
    assign general_port_pins_oe = s_r.pin_oe[7:0];
    assign irq_or_ninth_output_oe = s_r.pin_oe[8];
    assign readdata = s_r.rdata;
    assign waitrequest = s_r.wait_r;
    assign standby = s_r.standby;
    assign irq = s_r.irq;

endmodule : gle_expander

// File: gle_pkg.sv
package gle_pkg;

    localparam int CLK_PERIOD_NS = 5;
    localparam int OSC_PERIOD_NS = 31250;
    localparam int OSC_TICK_CYCLES = OSC_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [7:0] PWM_LAST_TICK = 8'hef;

    localparam logic [7:0] OFS_INPUT = 8'h00;
    localparam logic [7:0] OFS_PHASE0 = 8'h04;
    localparam logic [7:0] OFS_CONFIG = 8'h08;
    localparam logic [7:0] OFS_DIR = 8'h0c;
    localparam logic [7:0] OFS_PHASE1 = 8'h10;
    localparam logic [7:0] OFS_PWM_EN = 8'h14;
    localparam logic [7:0] OFS_MASTER = 8'h18;
    localparam logic [7:0] OFS_INTENS = 8'h1c;
    localparam logic [7:0] OFS_INTENS8 = 8'h20;
    localparam logic [7:0] OFS_CMD = 8'h24;
    localparam logic [7:0] OFS_DATA = 8'h28;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h2c;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h30;
    localparam logic [7:0] OFS_IRQ_EN = 8'h34;
    localparam logic [7:0] OFS_STATUS = 8'h38;

    localparam logic [7:0] DIR_RST = 8'hff;
    localparam logic [8:0] PHASE_RST = 9'h1ff;

    localparam int EV_CHANGE = 0;
    localparam int EV_BUS_START = 1;
    localparam int EV_STANDBY = 2;

    typedef struct packed {
        logic irq_mode;
        logic global_int;
        logic flip;
        logic blink_en;
    } gle_cfg_t;

    localparam gle_cfg_t CFG_RST = 4'h8;

    typedef struct packed {
        logic [7:0] port_s1;
        logic [7:0] port_s2;
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic [7:0] snap;
        logic [7:0] dir;
        logic [8:0] ph0;
        logic [8:0] ph1;
        logic [8:0] pwm_en;
        gle_cfg_t cfg;
        logic [3:0] master;
        logic [8:0][3:0] intens;
        logic [3:0] glob;
        logic [5:0] cmd;
        logic busy;
        logic pend;
        logic standby;
        logic [15:0] osc_div;
        logic [7:0] pwm_cnt;
        logic [8:0] pin_oe;
        logic [2:0] ev_stat;
        logic [2:0] ev_en;
        logic irq;
        logic wait_r;
        logic [31:0] rdata;
    } gle_state_t;

endpackage : gle_pkg

// File: gle_expander_assertions.sv
`timescale 1ns/100ps
module gle_expander_checker
    import gle_pkg::*;
#(
    parameter int OSC_TICKS = OSC_TICK_CYCLES
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic ce,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic [7:0] general_port_pins_out,
    input wire logic [7:0] general_port_pins_oe,
    input wire logic irq_or_ninth_output_out,
    input wire logic irq_or_ninth_output_oe,
    input wire logic standby
);
    gle_cfg_t cfg_wr;
    logic irq_mode_r;

    assign cfg_wr = gle_cfg_t'(writedata[3:0]);

    // Shadow of the ninth-pin mode; data-window writes and partial lanes not tracked
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            irq_mode_r <= CFG_RST.irq_mode;
        end else if (ce && write && !waitrequest && address[7:2] == OFS_CONFIG[7:2]) begin
            irq_mode_r <= cfg_wr.irq_mode;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    a_wait_one: assert property (ce && !waitrequest |=> waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_req_answer: assert property (ce && (read || write) && waitrequest |=> !waitrequest)
        else $error("request not answered after one cycle");
    a_idle_wait: assert property (!(read || write) |=> waitrequest)
        else $error("answer without a request");
    a_rd_zero: assert property (waitrequest |-> readdata == 32'h0)
        else $error("read data not zero outside answer");
    a_reset_inputs: assert property ($past(reset) |-> general_port_pins_oe == 8'h00)
        else $error("port driven right after reset");
    a_read_clears: assert property (irq_mode_r && ce && read && !waitrequest
        && address[7:2] == OFS_INPUT[7:2] |=> !irq_or_ninth_output_oe)
        else $error("change interrupt kept after read");
    a_standby_static: assert property ((standby && !write) [*3]
        |=> $stable(general_port_pins_oe)) else $error("outputs moved in standby");
    a_pins_low: assert property (!general_port_pins_out && !irq_or_ninth_output_out)
        else $error("open drain level not low");
    cover property (read && !waitrequest && address == OFS_INPUT);
    cover property ($fell(standby));
    cover property ($rose(irq_or_ninth_output_oe));
endmodule : gle_expander_checker

bind gle_expander gle_expander_checker #(.OSC_TICKS(OSC_TICKS)) i_chk (
    .clock(clock),
    .reset(reset),
    .ce(ce),
    .address(address),
    .read(read),
    .write(write),
    .writedata(writedata),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .general_port_pins_out(general_port_pins_out),
    .general_port_pins_oe(general_port_pins_oe),
    .irq_or_ninth_output_out(irq_or_ninth_output_out),
    .irq_or_ninth_output_oe(irq_or_ninth_output_oe),
    .standby(standby)
);

// File: gle_link_master.sv
`timescale 1ns/100ps
module gle_link_master (
    output logic scl,
    output logic sda
);
    // Pulled-up lines: idle high, clock stands still between frames
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // Address with write bit, command byte, then STOP; acks left released
    task automatic frame(input logic [17:0] b);
        sda = 1'b0;
        #32;
        for (int i = 17; i >= 0; i--) begin
            scl = 1'b0;
            sda = b[i];
            #32;
            scl = 1'b1;
            #32;
        end
        scl = 1'b0;
        sda = 1'b0;
        #32;
        scl = 1'b1;
        #32;
        sda = 1'b1;
    endtask : frame
endmodule : gle_link_master

// File: gle_expander_bench.sv
`timescale 1ns/100ps
module gle_expander_bench;
    import gle_pkg::*;
    logic clock = 0, reset = 1, read = 0, write = 0, waitrequest, standby, irq, n_out, n_oe;
    logic scl, sda, ce = 1;
    logic [7:0] address = 8'h00, pins = 8'h00, p_out, p_oe;
    logic [31:0] writedata = 32'h0, readdata, rd;
    int fail_count = 0, cmp_count = 0, cyc = 0, n;
    wire [7:0] lvl = pins & ~p_oe;
    always #2.5 clock = ~clock;
    gle_expander #(.OSC_TICKS(4)) i_dut (.clock(clock), .reset(reset), .ce(ce),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .byteenable(4'hf), .readdata(readdata), .waitrequest(waitrequest),
        .general_port_pins_in(lvl), .general_port_pins_out(p_out),
        .general_port_pins_oe(p_oe), .irq_or_ninth_output_out(n_out),
        .irq_or_ninth_output_oe(n_oe), .scl_in(scl), .sda_in(sda), .standby(standby), .irq(irq));
    gle_link_master i_link (.scl(scl), .sda(sda));
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        address <= a;
        writedata <= d;
        read <= !wr;
        write <= wr;
        do @(posedge clock); while (waitrequest !== 1'b0);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus
    task rdchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk("readdata", e, rd);
    endtask : rdchk
    task tick(input int k);
        repeat (k) @(posedge clock);
    endtask : tick
    task t_inputs;
        rdchk(OFS_DIR, 32'hff);
        chk("port oe", 8'h00, p_oe);
        pins <= 8'h5a;
        tick(4);
        rdchk(OFS_INPUT, 32'h5a);
        pins <= 8'h5b;
        tick(6);
        chk("ninth oe", 1'h1, n_oe);
        pins <= 8'h5a;
        tick(6);
        chk("ninth oe", 1'h0, n_oe);
        pins <= 8'h5b;
        tick(6);
        rdchk(OFS_INPUT, 32'h5b);
        tick(3);
        chk("ninth oe", 1'h0, n_oe);
        $display("inputs test done");
    endtask : t_inputs
    task t_irq;
        bus(1'b1, OFS_IRQ_EN, 32'h1);
        tick(2);
        chk("irq", 1'h1, irq);
        bus(1'b1, OFS_IRQ_CLR, 32'h7);
        tick(2);
        chk("irq", 1'h0, irq);
        fork
            i_link.frame({8'h40, 1'b1, 8'h03, 1'b1});
            begin
                tick(40);
                chk("standby", 1'h0, standby);
            end
        join
        tick(10);
        chk("standby", 1'h1, standby);
        chk("irq", 1'h0, irq);
        rdchk(OFS_IRQ_STAT, 32'h6);
        bus(1'b1, OFS_IRQ_EN, 32'h2);
        tick(2);
        chk("irq", 1'h1, irq);
        $display("interrupt test done");
    endtask : t_irq
    task t_outputs;
        bus(1'b1, OFS_CONFIG, 32'h2);
        bus(1'b1, OFS_DIR, 32'h0);
        bus(1'b1, OFS_PHASE0, 32'h1f0);
        bus(1'b1, OFS_PHASE1, 32'h00f);
        tick(3);
        chk("port oe", 8'h0f, p_oe);
        chk("ninth oe", 1'h0, n_oe);
        bus(1'b1, OFS_CONFIG, 32'h1);
        tick(3);
        chk("port oe", 8'h0f, p_oe);
        bus(1'b1, OFS_CONFIG, 32'h3);
        tick(3);
        chk("port oe", 8'hf0, p_oe);
        chk("ninth oe", 1'h1, n_oe);
        rdchk(OFS_INPUT, {24'h0, 8'h5b & 8'h0f});
        bus(1'b1, OFS_CMD, 32'h3);
        tick(3);
        chk("port oe", 8'hf0, p_oe);
        bus(1'b1, OFS_DATA, 32'hf0);
        tick(3);
        chk("port oe", 8'h00, p_oe);
        rdchk(OFS_DIR, 32'hf0);
        rdchk(8'hfc, 32'h0);
        // Clock enable low must hold a pending request unanswered
        ce <= 1'b0;
        fork
            rdchk(OFS_PHASE1, 32'h00f);
            begin
                tick(8);
                chk("waitrequest", 1'h1, waitrequest);
                ce <= 1'b1;
            end
        join
        $display("outputs test done");
    endtask : t_outputs
    task pwm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v, input int e);
        bus(1'b1, OFS_MASTER, m);
        bus(1'b1, a, v);
        tick(960);
        n = 0;
        repeat (960) begin
            @(posedge clock);
            n += (p_oe[0] === 1'b1);
            if (p_oe[1] !== 1'b1) n += 1000;
        end
        chk("sink cycles", e, n);
    endtask : pwm
    task t_pwm;
        bus(1'b1, OFS_CONFIG, 32'h0);
        bus(1'b1, OFS_DIR, 32'h0);
        bus(1'b1, OFS_PHASE0, 32'h0);
        bus(1'b1, OFS_PWM_EN, 32'h1);
        tick(5);
        chk("standby", 1'h0, standby);
        pwm(OFS_INTENS, 32'hf, 32'h8, 480);
        pwm(OFS_INTENS, 32'h5, 32'h3, 60);
        pwm(OFS_INTENS, 32'h0, 32'hf, 0);
        bus(1'b1, OFS_CONFIG, 32'h4);
        pwm(OFS_INTENS8, 32'hf, 32'h40, 240);
        bus(1'b1, OFS_PWM_EN, 32'h0);
        tick(5);
        chk("standby", 1'h1, standby);
        rdchk(OFS_STATUS, 32'h1);
        $display("pwm test done");
    endtask : t_pwm
    task end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test
    // Ceiling well above the roughly 8k cycles the tests need
    always @(posedge clock) begin
        cyc++;
        if (cyc == 40000) begin
            fail_count++;
            end_of_test;
        end
    end
    initial begin
        tick(4);
        reset <= 1'b0;
        t_inputs;
        t_irq;
        t_outputs;
        t_pwm;
        end_of_test;
    end
endmodule : gle_expander_bench
